// ===== src/pulse_stroke_scheduler.sv
// Purpose: Turns pulses or a manual setpoint into pump stroke requests.
// Assumes: Inputs from contacts are asynchronous; configuration is static-ish.
// Notes: Percent setpoints are in tenths of a percent, 0 to 1000; the calibrated setpoint is a flow.
// How it works
// - The selected operating mode decides how strokes are generated.
// - Manual mode runs at 0 to 100 percent in 0.1 percent steps, or 1 percent steps.
// - Pulse mode has four sub-modes: reduction, transmission, one-to-one, proportional.
// - Reduction gives one stroke after the factor of 1 to 999 pulses.
// - Transmission gives factor strokes, 1 to 999, per pulse.
// - One-to-one gives one stroke per pulse.
// - Proportional starts stroking at the base rate on the first pulse.
// - Proportional boosts the rate above the threshold and returns below it.
// - Proportional works only while the pulse memory is on.
// - The pulse memory can be switched and holds at most 999 strokes.
// - With memory on, excess pulses are stored and stroked later.
// - Pulse mode needs the pulse function on an input; defaults are input 1 and 2.
// - Calibrated manual mode takes a flow setpoint and converts it to a rate.
`timescale 1ns/10ps
module pulse_stroke_scheduler
  import stroke_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire stroke_pkg::cfg_t cfg,
  input wire logic [2:1] in_pin,
  output logic stroke,
  output logic [stroke_pkg::CNT_W-1:0] pending,
  output logic boosted,
  output logic stopped,
  output logic cfg_error
);
  import stroke_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:1] s1_ff, s2_ff, s3_ff;
  logic [2:1] nxt_s1, nxt_s2, nxt_s3;
  logic [2:1] lvl_ff, nxt_lvl;

  always_comb
  begin
    nxt_s1 = in_pin;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    nxt_lvl = lvl_ff;
    for (int i = 1; i <= 2; i++)
    begin
      if (s2_ff[i] == s3_ff[i])
      begin
        nxt_lvl[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
      s3_ff <= 2'h0;
      lvl_ff <= 2'h0;
    end
    else
    begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      lvl_ff <= nxt_lvl;
    end
  end

  function automatic logic pick(input logic [2:1] v, input logic [1:0] sel);
    pick = (sel == INPUT_ONE) ? v[1] : (sel == INPUT_TWO) ? v[2] : 1'b0;
  endfunction

  function automatic logic [RATE_W-1:0] pct_period(input logic [CNT_W-1:0] pct);
    logic [RATE_W-1:0] p;
    logic [2*RATE_W-1:0] q;
    p = {{(RATE_W-CNT_W){1'b0}}, pct};
    q = '0;
    if (pct == CNT_ZERO)
    begin
      pct_period = '0;
    end
    else
    begin
      q = (64'(FULL_PERIOD) * 64'(PCT_FULL)) / 64'(p);
      // Very low rates saturate instead of wrapping round to a short period.
      pct_period = (q[2*RATE_W-1:RATE_W] != '0) ? '1 : q[RATE_W-1:0];
    end
  endfunction

  // ****************************************
  // Pulse edge and stop
  // ****************************************
  logic pulse_lvl, pulse_edge, stop_in, pulse_assigned;
  logic prev_ff, nxt_prev;

  always_comb
  begin
    pulse_assigned = (cfg.pulse_input_sel == INPUT_ONE) || (cfg.pulse_input_sel == INPUT_TWO);
    pulse_lvl = pick(lvl_ff, cfg.pulse_input_sel);
    stop_in = pick(lvl_ff, cfg.stop_input_sel);
    nxt_prev = pulse_lvl;
    pulse_edge = pulse_lvl && !prev_ff && pulse_assigned;
  end

  // ****************************************
  // Scheduler state
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_FIRE = 3'b100
  } st_t;

  st_t st_ff, nxt_st;
  logic [CNT_W-1:0] div_ff, nxt_div;
  logic [CNT_W-1:0] pend_ff, nxt_pend;
  logic [RATE_W-1:0] tmr_ff, nxt_tmr;
  logic stroke_ff, nxt_stroke;
  logic boost_ff, nxt_boost;
  logic stop_ff, nxt_stop;
  logic err_ff, nxt_err;
  logic pulse_mode, prop_ok, cfg_bad;
  logic [CNT_W-1:0] add, room, pct, man_pct;
  logic [RATE_W-1:0] period;
  logic [RATE_W-1:0] flow_pct;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_div = div_ff;
    nxt_pend = pend_ff;
    nxt_tmr = tmr_ff;
    nxt_stroke = 1'b0;
    nxt_boost = boost_ff;
    add = CNT_ZERO;
    flow_pct = '0;
    pulse_mode = (cfg.mode == MODE_PULSE) && pulse_assigned;
    prop_ok = cfg.memory_on;
    cfg_bad = (cfg.factor == CNT_ZERO) || (cfg.factor > CNT_MAX)
      || ((cfg.sub == SUB_PROP) && !prop_ok);
    nxt_err = pulse_mode && cfg_bad;
    nxt_stop = pulse_mode && stop_in;
    // Manual setpoint: percent, or flow converted to percent when calibrated.
    man_pct = cfg.stepper ? cfg.setpoint
      : CNT_W'((cfg.setpoint / PCT_STEP_COARSE) * PCT_STEP_COARSE);
    if (cfg.calibrated)
    begin
      flow_pct = (cfg.flow_per_stroke == '0) ? '0
        : (RATE_W'(cfg.setpoint) * FLOW_UNIT) / cfg.flow_per_stroke;
      // Clip in full width first so a large quotient cannot wrap to a small rate.
      man_pct = (flow_pct > RATE_W'(PCT_FULL)) ? PCT_FULL : flow_pct[CNT_W-1:0];
    end
    if (man_pct > PCT_FULL)
    begin
      man_pct = PCT_FULL;
    end
    // Pulse intake per sub-mode.
    if (pulse_mode && !cfg_bad && pulse_edge)
    begin
      case (cfg.sub)
        SUB_REDUCE:
        begin
          if (div_ff + CNT_ONE >= cfg.factor)
          begin
            nxt_div = CNT_ZERO;
            add = CNT_ONE;
          end
          else
          begin
            nxt_div = div_ff + CNT_ONE;
          end
        end
        SUB_MULTIPLY: add = cfg.factor;
        SUB_ONE: add = CNT_ONE;
        SUB_PROP: add = CNT_ONE;
        default: add = CNT_ZERO;
      endcase
    end
    if (!cfg.memory_on && pend_ff != CNT_ZERO)
    begin
      add = CNT_ZERO;
    end
    room = CNT_MAX - pend_ff;
    if (add > room)
    begin
      add = room;
    end
    nxt_pend = pend_ff + add;
    if (!pulse_mode)
    begin
      nxt_pend = CNT_ZERO;
      nxt_div = CNT_ZERO;
    end
    // Rate selection.
    if (cfg.sub == SUB_PROP)
    begin
      if (pend_ff > cfg.threshold)
      begin
        nxt_boost = 1'b1;
      end
      else if (pend_ff < cfg.threshold)
      begin
        nxt_boost = 1'b0;
      end
    end
    else
    begin
      nxt_boost = 1'b0;
    end
    if (!pulse_mode)
    begin
      pct = (cfg.mode == MODE_MANUAL) ? man_pct : CNT_ZERO;
    end
    else if (cfg.sub == SUB_PROP)
    begin
      pct = boost_ff ? cfg.boost_pct : cfg.base_pct;
    end
    else
    begin
      pct = PCT_FULL;
    end
    period = pct_period(pct);
    // Stroke timer.
    case (st_ff)
      ST_IDLE:
      begin
        if (period != '0)
        begin
          if (!pulse_mode || (pend_ff != CNT_ZERO && !stop_in))
          begin
            nxt_st = ST_FIRE;
          end
        end
      end
      ST_FIRE:
      begin
        nxt_stroke = 1'b1;
        // A stroke started in another mode has nothing stored to take away.
        if (pulse_mode && nxt_pend != CNT_ZERO)
        begin
          nxt_pend = nxt_pend - CNT_ONE;
        end
        nxt_tmr = period;
        nxt_st = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (tmr_ff > RATE_ONE)
        begin
          nxt_tmr = tmr_ff - RATE_ONE;
        end
        else
        begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= ST_IDLE;
      prev_ff <= 1'b0;
      div_ff <= CNT_ZERO;
      pend_ff <= CNT_ZERO;
      tmr_ff <= '0;
      stroke_ff <= 1'b0;
      boost_ff <= 1'b0;
      stop_ff <= 1'b0;
      err_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      prev_ff <= nxt_prev;
      div_ff <= nxt_div;
      pend_ff <= nxt_pend;
      tmr_ff <= nxt_tmr;
      stroke_ff <= nxt_stroke;
      boost_ff <= nxt_boost;
      stop_ff <= nxt_stop;
      err_ff <= nxt_err;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign stroke = stroke_ff;
  assign pending = pend_ff;
  assign boosted = boost_ff;
  assign stopped = stop_ff;
  assign cfg_error = err_ff;

endmodule // pulse_stroke_scheduler

// ===== src/stroke_pkg.sv
// Purpose: Shared constants and types for the pump stroke scheduler.
// Assumes: One 40 MHz clock.
// Notes: Rates are stroke periods in clock cycles at full speed.
package stroke_pkg;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [2:0] {
    MODE_MANUAL = 3'h0,
    MODE_PULSE = 3'h1,
    MODE_ANALOG = 3'h2,
    MODE_BATCH = 3'h3,
    MODE_TIMER = 3'h4
  } op_mode_t;

  typedef enum logic [1:0] {
    SUB_REDUCE = 2'h0,
    SUB_MULTIPLY = 2'h1,
    SUB_ONE = 2'h2,
    SUB_PROP = 2'h3
  } sub_mode_t;

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3e7;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] PCT_FULL = 10'h3e8;
  localparam logic [CNT_W-1:0] PCT_STEP_COARSE = 10'h00a;
  localparam int RATE_W = 32;
  localparam int CLK_HZ = 40000000;
  localparam int STROKE_HZ_MAX = 4;
  localparam logic [RATE_W-1:0] FULL_PERIOD = RATE_W'(CLK_HZ / STROKE_HZ_MAX);
  localparam logic [RATE_W-1:0] FLOW_UNIT = 32'h0000_0001;
  localparam logic [RATE_W-1:0] RATE_ONE = 32'h0000_0001;
  localparam logic [1:0] INPUT_ONE = 2'h1;
  localparam logic [1:0] INPUT_TWO = 2'h2;

  typedef struct packed {
    op_mode_t mode;
    sub_mode_t sub;
    logic memory_on;
    logic stepper;
    logic calibrated;
    logic [CNT_W-1:0] factor;
    logic [CNT_W-1:0] threshold;
    logic [CNT_W-1:0] setpoint;
    logic [RATE_W-1:0] flow_per_stroke;
    logic [1:0] pulse_input_sel;
    logic [1:0] stop_input_sel;
    logic [CNT_W-1:0] base_pct;
    logic [CNT_W-1:0] boost_pct;
  } cfg_t;

endpackage : stroke_pkg

// ===== dv/pulse_stroke_scheduler_monitor.sv
// Purpose: Port checker for the stroke scheduler.
// Assumes: Configuration is held steady within a test.
// Notes: Bound to the top module.
`timescale 1ns/10ps
module stroke_monitor
  import stroke_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire stroke_pkg::cfg_t cfg,
  input wire logic [2:1] in_pin,
  input wire logic stroke,
  input wire logic [stroke_pkg::CNT_W-1:0] pending,
  input wire logic boosted,
  input wire logic stopped,
  input wire logic cfg_error
);
  logic pm;
  logic stp;
  logic pr;
  assign pm = cfg.mode == MODE_PULSE
    && (cfg.pulse_input_sel == INPUT_ONE || cfg.pulse_input_sel == INPUT_TWO);
  assign pr = pm && cfg.sub == SUB_PROP && cfg.memory_on;
  assign stp = in_pin[1] && cfg.stop_input_sel == INPUT_ONE
    || in_pin[2] && cfg.stop_input_sel == INPUT_TWO;
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_stop; (pm && stp) [*8]; endsequence
  sequence s_over; (pr && pending > cfg.threshold) [*3]; endsequence
  property p_stop; s_stop |-> stopped; endproperty
  a_stop: assert property (p_stop) else $error("stop not flagged");
  property p_hold; stopped |-> !stroke; endproperty
  a_hold: assert property (p_hold) else $error("stroke while stopped");
  property p_err; pm && cfg_error |-> !stroke; endproperty
  a_err: assert property (p_err) else $error("stroke with bad setup");
  property p_bad;
    (pm && (cfg.factor == CNT_ZERO || cfg.factor > CNT_MAX
      || cfg.sub == SUB_PROP && !cfg.memory_on)) [*2] |-> cfg_error;
  endproperty
  a_bad: assert property (p_bad) else $error("bad setup not flagged");
  property p_boost; s_over |-> boosted; endproperty
  a_boost: assert property (p_boost) else $error("boost missing");
  property p_nomem;
    !cfg.memory_on && pending != CNT_ZERO |=> pending <= $past(pending);
  endproperty
  a_nomem: assert property (p_nomem) else $error("pulse stored while busy");
  property p_idle; (cfg.mode > MODE_PULSE) [*2] |-> !stroke; endproperty
  a_idle: assert property (p_idle) else $error("stroke in idle mode");
  property p_cap; pending <= CNT_MAX; endproperty
  a_cap: assert property (p_cap) else $error("memory above limit");
endmodule // stroke_monitor
bind pulse_stroke_scheduler stroke_monitor mon (.clk(clk), .rst(rst), .cfg(cfg),
  .in_pin(in_pin), .stroke(stroke), .pending(pending), .boosted(boosted),
  .stopped(stopped), .cfg_error(cfg_error));

// ===== dv/pulse_source.sv
// Purpose: Pulse contact model feeding the pulse input.
// Assumes: Changes just after the rising edge.
// Notes: Contact idles low between pulses.
`timescale 1ns/10ps
module pulse_source (
  input wire logic clk,
  input wire logic go,
  input wire logic [9:0] count,
  input wire logic [7:0] gap,
  output logic pin,
  output logic busy
);
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      #2;
      if (go)
      begin
        busy = 1'b1;
        repeat (count)
        begin
          pin = 1'b1;
          repeat (4) @(posedge clk);
          #2 pin = 1'b0;
          repeat (gap) @(posedge clk);
          #2;
        end
        busy = 1'b0;
      end
    end
  end
endmodule // pulse_source

// ===== dv/pulse_stroke_scheduler_bench.sv
// Purpose: Self-checking bench for the stroke scheduler.
// Assumes: The stroke period far exceeds the run.
// Notes: Stop holds strokes while pulses are counted.
`timescale 1ns/10ps
module pulse_stroke_scheduler_bench;
  import stroke_pkg::*;
  typedef struct {
    sub_mode_t sub;
    logic mem;
    logic [9:0] fac;
    logic [9:0] n;
    logic [9:0] exp;
    logic bst;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stop = 1'b0;
  logic go = 1'b0;
  logic pin1, busy, stroke, boosted, stopped, cfg_error;
  logic [9:0] pending;
  logic [9:0] count = 10'h000;
  logic [7:0] gap = 8'h04;
  cfg_t cfg;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  row_t rows[8];
  always #12.5 clk = ~clk;
  pulse_source src (.clk(clk), .go(go), .count(count), .gap(gap), .pin(pin1), .busy(busy));
  pulse_stroke_scheduler dut (.clk(clk), .rst(rst), .cfg(cfg), .in_pin({stop, pin1}),
    .stroke(stroke), .pending(pending), .boosted(boosted), .stopped(stopped),
    .cfg_error(cfg_error));
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic pulses(input logic [9:0] k);
    count = k;
    go = 1'b1;
    step(2);
    go = 1'b0;
    for (int t = 0; t < 20000 && busy; t++) step(1);
    step(8);
  endtask
  task automatic setup(input sub_mode_t s, input logic m, input logic [9:0] f);
    cfg.mode = MODE_TIMER;
    cfg.sub = s;
    cfg.memory_on = m;
    cfg.factor = f;
    stop = 1'b1;
    // The wait after a stroke outlasts the run, so each setup starts from reset.
    rst = 1'b1;
    step(1);
    rst = 1'b0;
    step(3);
    cfg.mode = MODE_PULSE;
    step(8);
  endtask
  task automatic manual(input logic stp, input logic cal, input logic [9:0] sp,
    input logic [31:0] flow, input logic exp);
    cfg.mode = MODE_TIMER;
    cfg.stepper = stp;
    cfg.calibrated = cal;
    cfg.setpoint = sp;
    cfg.flow_per_stroke = flow;
    rst = 1'b1;
    step(1);
    rst = 1'b0;
    cfg.mode = MODE_MANUAL;
    for (int t = 0; t < 8 && stroke !== 1'b1; t++) step(1);
    chk(stroke, exp);
    chk(stopped, 1'b0);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    cfg = '0;
    cfg.mode = MODE_TIMER;
    cfg.pulse_input_sel = INPUT_ONE;
    cfg.stop_input_sel = INPUT_TWO;
    cfg.threshold = 10'h002;
    cfg.base_pct = 10'h3e8;
    cfg.boost_pct = 10'h3e8;
    rows = '{'{SUB_ONE, 1'b1, 10'h001, 10'h005, 10'h005, 1'b0},
      '{SUB_REDUCE, 1'b1, 10'h003, 10'h007, 10'h002, 1'b0},
      '{SUB_REDUCE, 1'b1, 10'h3e7, 10'h3e7, 10'h001, 1'b0},
      '{SUB_MULTIPLY, 1'b1, 10'h004, 10'h003, 10'h00c, 1'b0},
      '{SUB_MULTIPLY, 1'b1, 10'h3e7, 10'h002, 10'h3e7, 1'b0},
      '{SUB_ONE, 1'b0, 10'h001, 10'h004, 10'h001, 1'b0},
      '{SUB_PROP, 1'b1, 10'h001, 10'h003, 10'h003, 1'b1},
      '{SUB_PROP, 1'b1, 10'h001, 10'h002, 10'h002, 1'b0}};
    step(6);
    chk({stroke, pending, boosted, stopped, cfg_error}, 32'h0);
    rst = 1'b0;
    foreach (rows[i])
    begin
      setup(rows[i].sub, rows[i].mem, rows[i].fac);
      chk(stopped, 1'b1);
      pulses(rows[i].n);
      chk(pending, rows[i].exp);
      chk(boosted, rows[i].bst);
      stop = 1'b0;
      for (int t = 0; t < 30 && stroke !== 1'b1; t++) step(1);
      chk(stroke, 1'b1);
      chk(pending, rows[i].exp - 10'h001);
    end
    setup(SUB_PROP, 1'b0, 10'h001);
    chk(cfg_error, 1'b1);
    gap = 8'h28;
    pulses(10'h002);
    chk(pending, 10'h000);
    setup(SUB_ONE, 1'b1, 10'h000);
    chk(cfg_error, 1'b1);
    cfg.pulse_input_sel = 2'h0;
    setup(SUB_ONE, 1'b1, 10'h001);
    pulses(10'h003);
    chk(pending, 10'h000);
    cfg.pulse_input_sel = INPUT_ONE;
    pulses(10'h002);
    chk(pending, 10'h002);
    rst = 1'b1;
    step(1);
    chk(pending, 10'h000);
    rst = 1'b0;
    step(2);
    manual(1'b1, 1'b0, 10'h005, 32'h0000_0000, 1'b1);
    manual(1'b0, 1'b0, 10'h005, 32'h0000_0000, 1'b0);
    manual(1'b0, 1'b1, 10'h001, 32'h0000_0000, 1'b0);
    manual(1'b0, 1'b1, 10'h001, 32'h0000_0001, 1'b1);
    conclude();
  end
endmodule // pulse_stroke_scheduler_bench
